// [damp_ff_defines.svh]
/*
 * Constants of the damping and feed-forward command path.
 * Assumes inclusion by bare name from the package and the module.
 */
// Functional notes
// - Four damping channels, at most two active
// - Damping only in modes 0, 3, 4, 6
// - Frequencies outside 10.0-200.0 Hz bypass channel
// - Each channel has own frequency and filter
// - Filter zero default; larger sharpens, adds ripple
// - Select 0 fixed one+two; 1 by input A
// - Select 2 decodes inputs to one channel
// - Select 3 follows command direction
// - Velocity command derived from position command
// - Velocity feed-forward scaled by percent gain
// - Velocity feed-forward lag in 0.01 ms
// - Deviation shrinks with (100 - gain)/100
// - Torque feed-forward from velocity command, scaled
// - Torque feed-forward has own lag filter
// - Analog feed-forward needs expansion bit 5
// - Conversion gain 0 to 9 invalid
// - Analog input 3 used elsewhere disables it
// - Positive voltage adds CCW, negative CW
// - Torque percent = 100*V/(gain*0.1)
`ifndef DAMP_FF_DEFINES_SVH
`define DAMP_FF_DEFINES_SVH
// ----------------------------------------
// Control modes allowing damping
// ----------------------------------------
`define MODE_POSITION 4'h0
`define MODE_POS_VEL 4'h3
`define MODE_POS_TRQ 4'h4
`define MODE_FULL_CLOSED 4'h6
// ----------------------------------------
// Band and scaling
// ----------------------------------------
`define DAMP_FREQ_MIN 16'h0064
`define DAMP_FREQ_MAX 16'h07d0
`define DAMP_FREQ_SHIFT 11
`define DAMP_FILT_SHIFT 8
`define PERCENT_FULL 32'sh00000064
`define AFF_ENABLE_BIT 5
`define AFF_GAIN_MIN 16'h000a
`define AFF_SCALE 32'sh0000000a
`define WORD_MAX 32'sh00007fff
`define WORD_MIN (-32'sh00008000)
`define RST_WORD 16'h0000
`define RST_ACTIVE 4'h0
`endif

// [damp_ff_pkg.sv]
/*
 * Types of the damping and feed-forward command path.
 * Assumes the defines header sits in the same folder.
 */
`include "damp_ff_defines.svh"
package damp_ff_pkg;
    typedef logic signed [15:0] word_t;
    typedef enum logic [1:0] {SEL_FIXED, SEL_INPUT_A, SEL_DECODE, SEL_DIRECTION} dsel_t;
endpackage

// [damp_ff_path.sv]
/*
 * Damping filters and velocity/torque feed-forward of the command path.
 * Assumes CYCLE_TICK is a one-clock pulse from logic on REF_CLK marking
 * each drive control cycle; select pins arrive asynchronously.
 */
`timescale 1ns/1ps
`include "damp_ff_defines.svh"
module damp_ff_path
    import damp_ff_pkg::*;
#(
    parameter int CYCLE_10US = 10
)(
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CYCLE_TICK,
    input wire logic [3:0] CONTROL_MODE_SETTING,
    input wire logic [1:0] DAMPING_SELECT_MODE,
    input wire logic VIBRATION_SELECT_IN_A,
    input wire logic VIBRATION_SELECT_IN_B,
    input wire logic [15:0] DAMP_FREQ_ONE,
    input wire logic [15:0] DAMP_FILTER_ONE,
    input wire logic [15:0] DAMP_FREQ_TWO,
    input wire logic [15:0] DAMP_FILTER_TWO,
    input wire logic [15:0] DAMP_FREQ_THREE,
    input wire logic [15:0] DAMP_FILTER_THREE,
    input wire logic [15:0] DAMP_FREQ_FOUR,
    input wire logic [15:0] DAMP_FILTER_FOUR,
    input wire logic signed [15:0] POS_CMD_DELTA,
    input wire logic signed [15:0] POS_LOOP_SPEED_CMD,
    input wire logic signed [15:0] VEL_LOOP_TORQUE_CMD,
    input wire logic [15:0] VFF_GAIN,
    input wire logic [15:0] VFF_FILTER,
    input wire logic [15:0] TFF_GAIN,
    input wire logic [15:0] TFF_FILTER,
    input wire logic [15:0] INERTIA_RATIO_SETTING,
    input wire logic [15:0] FUNCTION_EXPANSION_BITS,
    input wire logic [15:0] ANALOG_FF_CONVERSION_GAIN,
    input wire logic ANALOG_IN3_OTHER_USE,
    input wire logic signed [15:0] ANALOG_IN3_MV,
    output logic [3:0] DAMP_ACTIVE,
    output logic signed [15:0] POS_CMD_SHAPED,
    output logic signed [15:0] SPEED_CMD_OUT,
    output logic signed [15:0] TORQUE_CMD_OUT,
    output logic AFF_ACTIVE
);

    // Lag weight needs a positive cycle that fits a setting word
    if (CYCLE_10US < 1 || CYCLE_10US > 65535)
    begin : g_bad_cycle
        $error("CYCLE_10US out of range");
    end

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Clamp a wide result to the command word
    function automatic word_t sat16(input logic signed [39:0] v);
        if (v > 40'(`WORD_MAX))
            return word_t'(`WORD_MAX);
        else if (v < 40'(`WORD_MIN))
            return word_t'(`WORD_MIN);
        return word_t'(v);
    endfunction

    // Widen an unsigned setting with a zero sign bit; a plain cast would
    // turn the whole product unsigned and break shifts and divides of negatives
    function automatic logic signed [39:0] u40(input logic [15:0] v);
        return $signed({24'h000000, v});
    endfunction

    // First-order lag; tc in 0.01 ms, weight cycle/(tc+cycle)
    function automatic word_t lag_step(input word_t y, input word_t x, input logic [15:0] tc);
        logic signed [39:0] diff;
        logic signed [39:0] den;
        diff = 40'(x) - 40'(y);
        den = u40(tc) + 40'(CYCLE_10US);
        return sat16(40'(y) + (diff * 40'(CYCLE_10US)) / den);
    endfunction

    // Scale by a percent setting
    function automatic logic signed [39:0] pct(input word_t x, input logic [15:0] g);
        return (40'(x) * u40(g)) / 40'(`PERCENT_FULL);
    endfunction

    // Band limits in 0.1 Hz units
    function automatic logic in_band(input logic [15:0] f);
        return f >= `DAMP_FREQ_MIN && f <= `DAMP_FREQ_MAX;
    endfunction

    // ----------------------------------------
    // Select pin synchronisers
    // ----------------------------------------
    logic [1:0] s1_q, s2_q, s3_q, sel_q;
    logic [1:0] sel_d;

    // Value accepted only once last two stages agree
    always_comb
    begin
        sel_d = sel_q;
        if (s2_q == s3_q)
            sel_d = s3_q;
    end

    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            s1_q <= 2'h0;
            s2_q <= 2'h0;
            s3_q <= 2'h0;
            sel_q <= 2'h0;
        end
        else
        begin
            s1_q <= {VIBRATION_SELECT_IN_B, VIBRATION_SELECT_IN_A};
            s2_q <= s1_q;
            s3_q <= s2_q;
            sel_q <= sel_d;
        end
    end

    // ----------------------------------------
    // Control-cycle datapath
    // ----------------------------------------
    word_t chan_q [4];
    word_t chan_d [4];
    logic [3:0] act_q, act_d;
    logic neg_q, neg_d;
    word_t shaped_q, shaped_d, vfilt_q, vfilt_d, vprev_q, vprev_d;
    word_t tfilt_q, tfilt_d, spd_q, spd_d, trq_q, trq_d;
    logic aff_q, aff_d;
    logic mode_ok;
    logic [15:0] freq [4];
    logic [15:0] filt [4];
    word_t stage;
    word_t acc_raw;
    logic signed [39:0] aff_t;

    // Settings gathered so the four channels share one loop
    assign freq = '{DAMP_FREQ_ONE, DAMP_FREQ_TWO, DAMP_FREQ_THREE, DAMP_FREQ_FOUR};
    assign filt = '{DAMP_FILTER_ONE, DAMP_FILTER_TWO, DAMP_FILTER_THREE, DAMP_FILTER_FOUR};

    assign mode_ok = CONTROL_MODE_SETTING == `MODE_POSITION || CONTROL_MODE_SETTING == `MODE_POS_VEL
        || CONTROL_MODE_SETTING == `MODE_POS_TRQ || CONTROL_MODE_SETTING == `MODE_FULL_CLOSED;

    // Next state, taken only on the cycle tick
    always_comb
    begin
        chan_d = chan_q;
        act_d = act_q;
        neg_d = neg_q;
        shaped_d = shaped_q;
        vfilt_d = vfilt_q;
        vprev_d = vprev_q;
        tfilt_d = tfilt_q;
        spd_d = spd_q;
        trq_d = trq_q;
        aff_d = aff_q;
        stage = POS_CMD_DELTA;
        acc_raw = '0;
        aff_t = '0;
        if (CYCLE_TICK)
        begin
            // Zero delta keeps the last direction
            if (POS_CMD_DELTA < 0)
                neg_d = 1'b1;
            else if (POS_CMD_DELTA > 0)
                neg_d = 1'b0;
            // no case yields more than two channels
            case (dsel_t'(DAMPING_SELECT_MODE))
                SEL_FIXED: act_d = 4'b0011;
                SEL_INPUT_A: act_d = sel_q[0] ? 4'b1010 : 4'b0101;
                SEL_DECODE: act_d = 4'b0001 << sel_q;
                SEL_DIRECTION: act_d = neg_d ? 4'b1010 : 4'b0101;
                default: act_d = 4'b0011;
            endcase
            if (!mode_ok)
                act_d = 4'b0000;
            for (int i = 0; i < 4; i++)
            begin
                if (act_d[i] && in_band(freq[i]))
                begin
                    chan_d[i] = sat16(40'(chan_q[i])
                        + ((40'(stage) - 40'(chan_q[i])) * u40(freq[i]) >>> `DAMP_FREQ_SHIFT));
                    stage = sat16(40'(chan_d[i])
                        + ((40'(stage) - 40'(chan_d[i])) * u40(filt[i]) >>> `DAMP_FILT_SHIFT));
                end
                else
                    chan_d[i] = stage;
            end
            shaped_d = stage;
            vfilt_d = lag_step(vfilt_q, stage, VFF_FILTER);
            vprev_d = stage;
            acc_raw = sat16(((40'(stage) - 40'(vprev_q))
                * (40'(`PERCENT_FULL) + u40(INERTIA_RATIO_SETTING))) / 40'(`PERCENT_FULL));
            tfilt_d = lag_step(tfilt_q, acc_raw, TFF_FILTER);
            // percent gain; at 100 deviation nulls
            spd_d = sat16(40'(POS_LOOP_SPEED_CMD) + pct(vfilt_d, VFF_GAIN));
            aff_d = FUNCTION_EXPANSION_BITS[`AFF_ENABLE_BIT] && !ANALOG_IN3_OTHER_USE
                && ANALOG_FF_CONVERSION_GAIN >= `AFF_GAIN_MIN;
            // sign follows voltage, positive is CCW
            if (aff_d)
                aff_t = (40'(ANALOG_IN3_MV) * 40'(`AFF_SCALE)) / u40(ANALOG_FF_CONVERSION_GAIN);
            trq_d = sat16(40'(VEL_LOOP_TORQUE_CMD) + pct(tfilt_d, TFF_GAIN) + aff_t);
        end
    end

    // Register the cycle results
    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            for (int i = 0; i < 4; i++)
                chan_q[i] <= `RST_WORD;
            act_q <= `RST_ACTIVE;
            neg_q <= 1'b0;
            shaped_q <= `RST_WORD;
            vfilt_q <= `RST_WORD;
            vprev_q <= `RST_WORD;
            tfilt_q <= `RST_WORD;
            spd_q <= `RST_WORD;
            trq_q <= `RST_WORD;
            aff_q <= 1'b0;
        end
        else
        begin
            chan_q <= chan_d;
            act_q <= act_d;
            neg_q <= neg_d;
            shaped_q <= shaped_d;
            vfilt_q <= vfilt_d;
            vprev_q <= vprev_d;
            tfilt_q <= tfilt_d;
            spd_q <= spd_d;
            trq_q <= trq_d;
            aff_q <= aff_d;
        end
    end

    // Outputs come straight from the cycle registers
    assign DAMP_ACTIVE = act_q;
    assign POS_CMD_SHAPED = shaped_q;
    assign SPEED_CMD_OUT = spd_q;
    assign TORQUE_CMD_OUT = trq_q;
    assign AFF_ACTIVE = aff_q;

    // ----------------------------------------
    // Assertions and covers
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);

    AST_AT_MOST_TWO: assert property ($countones(DAMP_ACTIVE) <= 2)
        else $error("More than two damping channels active");
    AST_MODE_GATE: assert property (CYCLE_TICK && !mode_ok |=> DAMP_ACTIVE == 4'b0000)
        else $error("Damping active in a disallowed mode");
    AST_SEL_FIXED: assert property (CYCLE_TICK && mode_ok && DAMPING_SELECT_MODE == 2'h0
        |=> DAMP_ACTIVE == 4'b0011)
        else $error("Selection 0 did not give channels one and two");
    AST_SEL_DECODE: assert property (CYCLE_TICK && mode_ok && DAMPING_SELECT_MODE == 2'h2
        |=> DAMP_ACTIVE == (4'b0001 << $past(sel_q)))
        else $error("Selection 2 decode wrong");
    AST_SEL_DIR: assert property (CYCLE_TICK && mode_ok && DAMPING_SELECT_MODE == 2'h3
        && POS_CMD_DELTA < 0 |=> DAMP_ACTIVE == 4'b1010)
        else $error("Negative direction pair wrong");
    AST_AFF_GAIN: assert property (CYCLE_TICK && ANALOG_FF_CONVERSION_GAIN < 16'h000a
        |=> !AFF_ACTIVE)
        else $error("Analog feed-forward with invalid gain");
    AST_AFF_GATE: assert property (CYCLE_TICK && (!FUNCTION_EXPANSION_BITS[5] || ANALOG_IN3_OTHER_USE)
        |=> !AFF_ACTIVE)
        else $error("Analog feed-forward not gated off");
    AST_VFF_ZERO: assert property (CYCLE_TICK && VFF_GAIN == 16'h0000
        |=> SPEED_CMD_OUT == $past(POS_LOOP_SPEED_CMD))
        else $error("Zero gain still adds velocity feed-forward");
    AST_HOLD: assert property (!CYCLE_TICK |=> $stable(SPEED_CMD_OUT) && $stable(TORQUE_CMD_OUT))
        else $error("Outputs moved between cycle ticks");
    AST_ACT_HOLD: assert property (!CYCLE_TICK |=> $stable(DAMP_ACTIVE) && $stable(POS_CMD_SHAPED))
        else $error("Damping outputs moved between cycle ticks");
    AST_SEL_INPUT_A: assert property (CYCLE_TICK && mode_ok && DAMPING_SELECT_MODE == 2'h1
        |=> DAMP_ACTIVE == ($past(sel_q[0]) ? 4'b1010 : 4'b0101))
        else $error("Selection 1 pair wrong");
    AST_AFF_ON: assert property (CYCLE_TICK && FUNCTION_EXPANSION_BITS[5] && !ANALOG_IN3_OTHER_USE
        && ANALOG_FF_CONVERSION_GAIN >= 16'h000a |=> AFF_ACTIVE)
        else $error("Analog feed-forward not enabled");

    COV_DIR_POS: cover property (CYCLE_TICK && mode_ok && DAMPING_SELECT_MODE == 2'h3 ##1 DAMP_ACTIVE == 4'b0101);
    COV_DECODE_4: cover property (DAMP_ACTIVE == 4'b1000);
    COV_AFF_ON: cover property (AFF_ACTIVE ##1 TORQUE_CMD_OUT != 16'h0000);
    COV_SAT: cover property (SPEED_CMD_OUT == 16'h7fff);
    COV_INPUT_A: cover property (CYCLE_TICK && mode_ok && DAMPING_SELECT_MODE == 2'h1 ##1 DAMP_ACTIVE == 4'b1010);

endmodule // damp_ff_path

// [damp_host_model.sv]
/*
 * Host controller model: issues position command steps, select pins
 * and the control-cycle tick for the damping and feed-forward path.
 * Assumes the bench calls send() from its falling-edge driven sequence.
 */
`timescale 1ns/1ps
module damp_host_model (
    input wire logic clk,
    output logic tick,
    output logic signed [15:0] delta,
    output logic sel_a,
    output logic sel_b
);
    // ----------------------------------------
    // Idle state at time zero
    // ----------------------------------------
    initial
    begin
        tick = 1'b0;
        delta = 16'sh0000;
        sel_a = 1'b0;
        sel_b = 1'b0;
    end

    // ----------------------------------------
    // One control cycle of command
    // ----------------------------------------
    // command word steady across the tick
    // Pins lead the tick by four edges so the 3-FF sync has them
    task automatic send(input logic signed [15:0] d, input logic a, input logic b);
        @(negedge clk);
        delta = d;
        sel_a = a;
        sel_b = b;
        repeat (4) @(negedge clk);
        tick = 1'b1;
        @(negedge clk);
        tick = 1'b0;
        delta = ~d; // Word no longer valid; never repeat it
    endtask
endmodule // damp_host_model

// [damp_ff_path_tb_top.sv]
/*
 * Self-checking bench of the damping and feed-forward path.
 * Assumes the host model file and the design package are compiled first.
 */
`timescale 1ns/1ps
`include "damp_ff_defines.svh"
module damp_ff_path_tb_top;
    import damp_ff_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tick, sa, sb, aff;
    logic [3:0] act;
    logic signed [15:0] dl, shp, so, tq, d, es, et;
    logic signed [15:0] spd = 16'sh0000, trq = 16'sh0000, mv = 16'sh0000;
    logic [15:0] vg = 16'h0000, vf = 16'h0000, tg = 16'h0064, tf = 16'h0000;
    logic [15:0] inr = 16'h0064, fx = 16'h0000, ag = 16'h0000, r;
    logic [15:0] fq [4] = '{16'h01f4, 16'h01f4, 16'h01f4, 16'h01f4};
    logic [15:0] fl [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] ags [7] = '{16'h0000, 16'h0009, 16'h000a, 16'h0014, 16'h0019, 16'h0032, 16'h0064};
    logic [3:0] modes [8] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h1, 4'h2, 4'h5, 4'h7};
    logic [3:0] mode = 4'h0;
    logic [1:0] sel = 2'h0;
    logic oth = 1'b0;
    logic en;
    logic [31:0] rs = 32'h0000d1f5;
    int n_fail = 0;
    int comparisons = 0;
    int vy, vp, ty, ya, acc;

    // ----------------------------------------
    // Clock, design and host
    // ----------------------------------------
    always #12.5 clk = ~clk;

    damp_ff_path #(.CYCLE_10US(10)) i_dut (
        .REF_CLK(clk), .RESETN(rst_n), .CYCLE_TICK(tick), .CONTROL_MODE_SETTING(mode),
        .DAMPING_SELECT_MODE(sel), .VIBRATION_SELECT_IN_A(sa), .VIBRATION_SELECT_IN_B(sb),
        .DAMP_FREQ_ONE(fq[0]), .DAMP_FILTER_ONE(fl[0]), .DAMP_FREQ_TWO(fq[1]), .DAMP_FILTER_TWO(fl[1]),
        .DAMP_FREQ_THREE(fq[2]), .DAMP_FILTER_THREE(fl[2]), .DAMP_FREQ_FOUR(fq[3]),
        .DAMP_FILTER_FOUR(fl[3]), .POS_CMD_DELTA(dl), .POS_LOOP_SPEED_CMD(spd),
        .VEL_LOOP_TORQUE_CMD(trq), .VFF_GAIN(vg), .VFF_FILTER(vf), .TFF_GAIN(tg), .TFF_FILTER(tf),
        .INERTIA_RATIO_SETTING(inr), .FUNCTION_EXPANSION_BITS(fx), .ANALOG_FF_CONVERSION_GAIN(ag),
        .ANALOG_IN3_OTHER_USE(oth), .ANALOG_IN3_MV(mv), .DAMP_ACTIVE(act), .POS_CMD_SHAPED(shp),
        .SPEED_CMD_OUT(so), .TORQUE_CMD_OUT(tq), .AFF_ACTIVE(aff));

    damp_host_model i_host (.clk(clk), .tick(tick), .delta(dl), .sel_a(sa), .sel_b(sb));

    // ----------------------------------------
    // Reference functions and checks
    // ----------------------------------------
    function automatic logic [15:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[15:0];
    endfunction

    // Clamp instead of wrap, as the command words do
    function automatic logic signed [15:0] sat(input int v);
        return (v > 32767) ? 16'sh7fff : (v < -32768) ? 16'sh8000 : v[15:0];
    endfunction

    // First-order lag per control cycle of 10 x 0.01 ms
    function automatic int lag(input int y, input int x, input int tc);
        return sat(y + (x - y) * 10 / (tc + 10));
    endfunction

    function automatic logic [3:0] exp_act(input logic [3:0] m, input logic [1:0] s,
                                           input logic a, input logic b, input logic n);
        if (!(m inside {`MODE_POSITION, `MODE_POS_VEL, `MODE_POS_TRQ, `MODE_FULL_CLOSED}))
            return 4'h0;
        case (s)
            2'h0: return 4'h3;
            2'h1: return a ? 4'ha : 4'h5;
            2'h2: return 4'h1 << {b, a};
            default: return n ? 4'ha : 4'h5;
        endcase
    endfunction

    task automatic chk_w(input logic signed [15:0] got, input logic signed [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t flags got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Run needs about 60 us; a hang is cut well beyond that
    initial
    begin
        #500000;
        n_fail++;
        wrap_up();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        chk_b(act, 4'h0);
        chk_w(so, 16'sh0000);
        // Modes 0 to 7, every selection and pin pattern, random nonzero command
        foreach (modes[k])
            for (int s = 0; s < 16; s++)
            begin
                mode = modes[k];
                sel = s[3:2];
                fl[s[1:0]] = rnd() & 16'h00ff;
                d = rnd() | 16'h0001;
                i_host.send(d, s[0], s[1]);
                chk_b(act, exp_act(mode, sel, s[0], s[1], d[15]));
            end
        // Velocity feed-forward with out-of-band channels bypassed
        mode = `MODE_POSITION;
        sel = 2'h0;
        fq[0] = 16'h0032;
        fq[1] = 16'h0bb8;
        for (int i = 0; i < 40; i++)
        begin
            r = rnd();
            d = {r[15:1], 1'b0};
            vg = 16'h0032 * (i % 3);
            spd = rnd();
            trq = rnd();
            es = sat(int'(spd) + int'(d) * int'(vg) / 100);
            repeat (3) i_host.send(d, 1'b0, 1'b0);
            chk_w(shp, d);
            chk_w(so, es);
            chk_w(tq, trq);
        end
        // Lagged velocity and torque feed-forward on a changing command
        vf = 16'h000a;
        tf = 16'h0032;
        vg = 16'h0064;
        vy = d;
        vp = d;
        ty = 0;
        for (int i = 0; i < 8; i++)
        begin
            d = rnd();
            spd = rnd() & 16'h0fff;
            trq = rnd() & 16'h0fff;
            vy = lag(vy, d, 10);
            acc = sat((int'(d) - vp) * (100 + int'(inr)) / 100);
            ty = lag(ty, acc, 50);
            vp = d;
            i_host.send(d, 1'b0, 1'b0);
            chk_w(so, sat(int'(spd) + vy * int'(vg) / 100));
            chk_w(tq, sat(int'(trq) + ty * int'(tg) / 100));
        end
        vf = 16'h0000;
        tf = 16'h0000;
        // Analog feed-forward gating, sign and scale
        for (int i = 0; i < 40; i++)
        begin
            r = rnd();
            fx = rnd();
            ag = ags[r[2:0] % 7];
            oth = r[3] & r[4];
            mv = 16'sh0064 * ($signed(rnd()) % 41);
            trq = rnd();
            en = fx[`AFF_ENABLE_BIT] && ag >= `AFF_GAIN_MIN && !oth;
            et = sat(int'(trq) + (en ? 10 * int'(mv) / int'(ag) : 0));
            repeat (3) i_host.send(16'sh0000, 1'b0, 1'b0);
            chk_b({3'h0, aff}, {3'h0, en});
            chk_w(tq, et);
        end
        // Without a tick the outputs hold
        spd = ~spd;
        trq = ~trq;
        repeat (6) @(negedge clk);
        chk_w(tq, et);
        chk_w(so, sat(int'(~spd)));
        // In-band channel one shapes the command, channel two bypassed
        fq[0] = 16'h0400;
        fl[0] = rnd() & 16'h00ff;
        ya = 0;
        for (int i = 0; i < 8; i++)
        begin
            d = rnd();
            i_host.send(d, 1'b0, 1'b0);
            ya = sat(ya + ((int'(d) - ya) * 1024 >>> 11));
            chk_w(shp, sat(ya + ((int'(d) - ya) * int'(fl[0]) >>> 8)));
        end
        wrap_up();
    end
endmodule // damp_ff_path_tb_top
